/* shared/rcc_pkg.sv */
// Constants, field layout and types of the receiver configuration handler
package rcc_pkg;

  // ****************************************
  // Packet layout
  // ****************************************
  localparam int RCC_PKT_LEN = 43;
  localparam int RCC_QUERY_LEN = 1;
  localparam int RCC_B_SUB = 0;
  localparam int RCC_B_DIM = 1;
  localparam int RCC_B_DGPS = 2;
  localparam int RCC_B_DYN = 3;
  localparam int RCC_B_SOL = 4;
  localparam int RCC_B_ELEV = 5;
  localparam int RCC_B_SIG = 9;
  localparam int RCC_B_PMASK = 13;
  localparam int RCC_B_PSW = 17;
  localparam int RCC_B_AGE = 21;
  localparam int RCC_B_FOL = 22;
  localparam int RCC_B_RSV0 = 23;
  localparam int RCC_B_MEAS = 25;
  localparam int RCC_B_FIX = 26;
  localparam int RCC_B_RSV1 = 27;

  // ****************************************
  // Codes
  // ****************************************
  localparam logic [7:0] RCC_SUB_PRIMARY = 8'h00;
  localparam logic [7:0] RCC_KEEP_BYTE = 8'hff;
  localparam logic [7:0] RCC_RSVD_BYTE = 8'hff;
  localparam logic [31:0] RCC_KEEP_FLOAT = 32'hbf800000;
  localparam logic [31:0] RCC_ELEV_MAX = 32'h3fc90fdb;
  localparam logic [7:0] RCC_DIM_AUTO = 8'h00;
  localparam logic [7:0] RCC_DIM_1SV = 8'h01;
  localparam logic [7:0] RCC_DIM_2D = 8'h03;
  localparam logic [7:0] RCC_DIM_3D = 8'h04;
  localparam logic [7:0] RCC_DIM_DREF = 8'h05;
  localparam logic [7:0] RCC_DIM_2DHOLD = 8'h06;
  localparam logic [7:0] RCC_DIM_OVER = 8'h07;
  localparam logic [7:0] RCC_DGPS_OFF = 8'h00;
  localparam logic [7:0] RCC_DGPS_REQ = 8'h01;
  localparam logic [7:0] RCC_DGPS_AUTO = 8'h03;
  localparam logic [7:0] RCC_DYN_LAND = 8'h01;
  localparam logic [7:0] RCC_DYN_SEA = 8'h02;
  localparam logic [7:0] RCC_DYN_AIR = 8'h03;
  localparam logic [7:0] RCC_DYN_STATIC = 8'h04;
  localparam logic [7:0] RCC_SOL_OVER = 8'h01;
  localparam logic [7:0] RCC_FOL_NEVER = 8'h00;
  localparam logic [7:0] RCC_RATE_1HZ = 8'h00;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] RCC_ELEV_RST = 32'h3e32b021;
  localparam logic [31:0] RCC_SIG_RST = 32'h40800000;
  localparam logic [31:0] RCC_PMASK_RST = 32'h41000000;
  localparam logic [31:0] RCC_PSW_RST = 32'h40c00000;
  localparam logic [7:0] RCC_AGE_RST = 8'h1e;
  localparam logic [31:0] RCC_HYST_DEFAULT = 32'h00100000;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [7:0] dim;
    logic [7:0] dgps;
    logic [7:0] dyn;
    logic [7:0] sol;
    logic [31:0] elev;
    logic [31:0] sig;
    logic [31:0] pmask;
    logic [31:0] psw;
    logic [7:0] age;
    logic [7:0] fol;
    logic [7:0] meas;
    logic [7:0] fix;
  } rcc_cfg_t;

  localparam rcc_cfg_t RCC_CFG_RESET = '{
    dim: RCC_DIM_3D, dgps: RCC_DGPS_AUTO, dyn: RCC_DYN_LAND, sol: RCC_SOL_OVER,
    elev: RCC_ELEV_RST, sig: RCC_SIG_RST, pmask: RCC_PMASK_RST, psw: RCC_PSW_RST,
    age: RCC_AGE_RST, fol: RCC_FOL_NEVER, meas: RCC_RATE_1HZ, fix: RCC_RATE_1HZ};

  typedef enum logic [1:0] {RCC_SURV_OFF, RCC_SURV_ACTIVE, RCC_SURV_DONE} rcc_survey_t;
  typedef enum logic {RCC_REP_IDLE, RCC_REP_SEND} rcc_rep_t;

endpackage

/* shared/rcc_sat_if.sv */
// Satellite level check signals between the handler and its hysteresis filter
`timescale 1ns/1ns
`default_nettype none
interface rcc_sat_if;
  logic [31:0] level;
  logic [31:0] threshold;
  logic valid;
  logic in_use;
  logic admit;
  modport filt (input level, input threshold, input valid, input in_use, output admit);
  modport ctrl (output level, output threshold, output valid, output in_use, input admit);
endinterface
`default_nettype wire

/* hdl/rcc_sat_filter.sv */
// Hysteresis compare of a satellite signal level against the level threshold
`timescale 1ns/1ns
`default_nettype none
module rcc_sat_filter
  import rcc_pkg::*;
#(
  parameter logic [31:0] HYST = RCC_HYST_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Level check
  rcc_sat_if.filt sat
);

  logic admit;
  logic next_admit;
  logic [31:0] low_lim;
  logic [31:0] high_lim;

  // ****************************************
  // Compare on raw positive float codes
  // ****************************************
  always_comb begin
    low_lim = (sat.threshold > HYST) ? sat.threshold - HYST : 32'h00000000;
    high_lim = sat.threshold + HYST;
    next_admit = admit;
    if (sat.valid) begin
      if (sat.level[31]) begin
        next_admit = 1'b0;
      end else if (sat.in_use) begin
        next_admit = (sat.level >= low_lim);
      end else begin
        next_admit = (sat.level > high_lim);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      admit <= 1'b0;
    end else begin
      admit <= next_admit;
    end
  end

  assign sat.admit = admit;

endmodule
`default_nettype wire

/* hdl/rcc_top.sv */
// Primary receiver configuration command handler with three configuration sets
`timescale 1ns/1ns
`default_nettype none

// Function
// - Three configuration sets; survey state selects mobile, survey or timing set.
// - Survey state change switches active set with no command.
// - Writes update only the active set.
// - Survey and timing sets restrict dynamics and dimension codes.
// - Single subcode-0 byte is a query; answer with full active set report.
// - Byte 0xFF or float -1.0 leaves the field unchanged.
// - Dimension codes 0,1,3,4,5,6,7; reset default full 3D.
// - Differential mode codes 0,1,3; default automatic.
// - Dynamics codes 1 to 4; default land.
// - Elevation mask float bytes 5-8, zero to half pi, default 0.1745.
// - Signal level threshold float bytes 9-12, default 4.0.
// - Dilution mask bytes 13-16 default 8; switch bytes 17-20 default 6.
// - Switch threshold used only in automatic dimension.
// - Age limit, foliage, rates decoded; reserved bytes ignored.
// - Hysteresis on signal level threshold for used and new satellites.
module rcc_top
  import rcc_pkg::*;
#(
  parameter logic [31:0] HYST = RCC_HYST_DEFAULT
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // Survey state
  input wire logic [1:0] SURVEY_STATE,
  // Command byte stream
  input wire logic PKT_VALID,
  input wire logic PKT_FIRST,
  input wire logic PKT_LAST,
  input wire logic [7:0] PKT_DATA,
  output logic PKT_READY,
  // Report byte stream
  output logic REP_VALID,
  output logic REP_LAST,
  output logic [7:0] REP_DATA,
  input wire logic REP_READY,
  // Command status
  output logic CMD_DONE,
  output logic CMD_ERROR,
  output logic [1:0] ACTIVE_SET,
  // Active configuration
  output logic [7:0] CFG_DIM,
  output logic [7:0] CFG_DGPS,
  output logic [7:0] CFG_DYN,
  output logic [31:0] CFG_ELEV,
  output logic [31:0] CFG_SIG,
  output logic [31:0] CFG_PDOP_MASK,
  output logic [31:0] CFG_PDOP_SWITCH,
  output logic CFG_SWITCH_EN,
  output logic [7:0] CFG_AGE,
  // Satellite level check
  input wire logic SAT_VALID,
  input wire logic SAT_IN_USE,
  input wire logic [31:0] SAT_LEVEL,
  output logic SAT_ADMIT
);

  // ****************************************
  // Survey state and active set
  // ****************************************
  rcc_survey_t act_state;
  rcc_survey_t next_act_state;

  always_comb begin
    next_act_state = act_state;
    unique case (SURVEY_STATE)
      2'h0: next_act_state = RCC_SURV_OFF;
      2'h1: next_act_state = RCC_SURV_ACTIVE;
      2'h2: next_act_state = RCC_SURV_DONE;
      default: next_act_state = act_state;
    endcase
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      act_state <= RCC_SURV_OFF;
    end else begin
      act_state <= next_act_state;
    end
  end

  // ****************************************
  // Command receive buffer
  // ****************************************
  logic [7:0] rx_buf [RCC_PKT_LEN];
  logic [7:0] next_rx_buf [RCC_PKT_LEN];
  logic [5:0] rx_cnt;
  logic [5:0] next_rx_cnt;
  logic [5:0] rx_idx;
  logic rx_take;
  logic do_query;
  logic do_write;
  logic bad_cmd;
  rcc_rep_t rep_state;

  assign PKT_READY = (rep_state == RCC_REP_IDLE);
  assign rx_take = PKT_VALID && PKT_READY;
  assign rx_idx = PKT_FIRST ? 6'h00 : rx_cnt;

  always_comb begin
    next_rx_buf = rx_buf;
    next_rx_cnt = rx_cnt;
    do_query = 1'b0;
    do_write = 1'b0;
    bad_cmd = 1'b0;
    if (rx_take) begin
      if (rx_idx < 6'(RCC_PKT_LEN)) begin
        next_rx_buf[rx_idx] = PKT_DATA;
        next_rx_cnt = rx_idx + 6'h01;
      end else begin
        next_rx_cnt = 6'(RCC_PKT_LEN + 1);
      end
      if (PKT_LAST) begin
        next_rx_cnt = 6'h00;
        if (rx_idx == 6'(RCC_QUERY_LEN - 1) && PKT_DATA == RCC_SUB_PRIMARY) begin
          do_query = 1'b1;
        end else if (rx_idx == 6'(RCC_PKT_LEN - 1) && rx_buf[RCC_B_SUB] == RCC_SUB_PRIMARY) begin
          do_write = 1'b1;
        end else begin
          bad_cmd = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rx_cnt <= 6'h00;
      for (int i = 0; i < RCC_PKT_LEN; i++) begin
        rx_buf[i] <= 8'h00;
      end
    end else begin
      rx_cnt <= next_rx_cnt;
      rx_buf <= next_rx_buf;
    end
  end

  // ****************************************
  // Field checks
  // ****************************************
  function automatic logic [31:0] get32(input int b);
    get32 = {rx_buf[b], rx_buf[b+1], rx_buf[b+2], rx_buf[b+3]};
  endfunction

  function automatic logic dim_ok(input logic [7:0] v, input rcc_survey_t s);
    logic legal;
    legal = (v == RCC_DIM_AUTO) || (v == RCC_DIM_1SV) || (v == RCC_DIM_2D) ||
            (v == RCC_DIM_3D) || (v == RCC_DIM_DREF) || (v == RCC_DIM_2DHOLD) ||
            (v == RCC_DIM_OVER);
    unique case (s)
      RCC_SURV_ACTIVE: dim_ok = (v == RCC_DIM_AUTO) || (v == RCC_DIM_2D) ||
                                (v == RCC_DIM_3D);
      RCC_SURV_DONE: dim_ok = (v == RCC_DIM_1SV) || (v == RCC_DIM_OVER);
      RCC_SURV_OFF: dim_ok = legal;
    endcase
  endfunction

  function automatic logic dyn_ok(input logic [7:0] v, input rcc_survey_t s);
    unique case (s)
      RCC_SURV_ACTIVE: dyn_ok = (v >= RCC_DYN_LAND) && (v <= RCC_DYN_AIR);
      RCC_SURV_DONE: dyn_ok = (v == RCC_DYN_STATIC);
      RCC_SURV_OFF: dyn_ok = (v >= RCC_DYN_LAND) && (v <= RCC_DYN_STATIC);
    endcase
  endfunction

  // ****************************************
  // Configuration sets
  // ****************************************
  rcc_cfg_t sets [3];
  rcc_cfg_t next_sets [3];
  rcc_cfg_t upd;
  logic [7:0] b;
  logic [31:0] f;

  always_comb begin
    next_sets = sets;
    upd = sets[act_state];
    b = 8'h00;
    f = 32'h00000000;
    if (do_write) begin
      b = rx_buf[RCC_B_DIM];
      if (b != RCC_KEEP_BYTE && dim_ok(b, act_state)) upd.dim = b;
      b = rx_buf[RCC_B_DGPS];
      if (b == RCC_DGPS_OFF || b == RCC_DGPS_REQ || b == RCC_DGPS_AUTO) upd.dgps = b;
      b = rx_buf[RCC_B_DYN];
      if (b != RCC_KEEP_BYTE && dyn_ok(b, act_state)) upd.dyn = b;
      if (rx_buf[RCC_B_SOL] == RCC_SOL_OVER) upd.sol = RCC_SOL_OVER;
      f = get32(RCC_B_ELEV);
      if (f != RCC_KEEP_FLOAT && !f[31] && f <= RCC_ELEV_MAX) upd.elev = f;
      f = get32(RCC_B_SIG);
      if (f != RCC_KEEP_FLOAT) upd.sig = f;
      f = get32(RCC_B_PMASK);
      if (f != RCC_KEEP_FLOAT) upd.pmask = f;
      f = get32(RCC_B_PSW);
      if (f != RCC_KEEP_FLOAT) upd.psw = f;
      b = rx_buf[RCC_B_AGE];
      if (b != RCC_KEEP_BYTE) upd.age = b;
      if (rx_buf[RCC_B_FOL] == RCC_FOL_NEVER) upd.fol = RCC_FOL_NEVER;
      if (rx_buf[RCC_B_MEAS] == RCC_RATE_1HZ) upd.meas = RCC_RATE_1HZ;
      if (rx_buf[RCC_B_FIX] == RCC_RATE_1HZ) upd.fix = RCC_RATE_1HZ;
      next_sets[act_state] = upd;
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int i = 0; i < 3; i++) begin
        sets[i] <= RCC_CFG_RESET;
      end
    end else begin
      sets <= next_sets;
    end
  end

  // ****************************************
  // Report generator
  // ****************************************
  rcc_rep_t next_rep_state;
  rcc_cfg_t rep_cfg;
  rcc_cfg_t next_rep_cfg;
  logic [5:0] rep_idx;
  logic [5:0] next_rep_idx;
  logic [7:0] rep_data;
  logic [7:0] next_rep_data;

  function automatic logic [7:0] rep_byte(input rcc_cfg_t c, input logic [5:0] i);
    logic [31:0] fs;
    logic [1:0] k;
    fs = (i < 6'(RCC_B_SIG)) ? c.elev : (i < 6'(RCC_B_PMASK)) ? c.sig :
         (i < 6'(RCC_B_PSW)) ? c.pmask : c.psw;
    k = 2'(i - 6'(RCC_B_ELEV));
    if (i == 6'(RCC_B_SUB)) rep_byte = RCC_SUB_PRIMARY;
    else if (i == 6'(RCC_B_DIM)) rep_byte = c.dim;
    else if (i == 6'(RCC_B_DGPS)) rep_byte = c.dgps;
    else if (i == 6'(RCC_B_DYN)) rep_byte = c.dyn;
    else if (i == 6'(RCC_B_SOL)) rep_byte = c.sol;
    else if (i < 6'(RCC_B_AGE)) rep_byte = fs[6'd31 - {k, 3'b000} -: 8];
    else if (i == 6'(RCC_B_AGE)) rep_byte = c.age;
    else if (i == 6'(RCC_B_FOL)) rep_byte = c.fol;
    else if (i == 6'(RCC_B_MEAS)) rep_byte = c.meas;
    else if (i == 6'(RCC_B_FIX)) rep_byte = c.fix;
    else rep_byte = RCC_RSVD_BYTE;
  endfunction

  always_comb begin
    next_rep_state = rep_state;
    next_rep_cfg = rep_cfg;
    next_rep_idx = rep_idx;
    next_rep_data = rep_data;
    unique case (rep_state)
      RCC_REP_IDLE: begin
        if (do_query) begin
          next_rep_state = RCC_REP_SEND;
          next_rep_cfg = sets[act_state];
          next_rep_idx = 6'h00;
          next_rep_data = rep_byte(sets[act_state], 6'h00);
        end
      end
      RCC_REP_SEND: begin
        if (REP_READY) begin
          if (rep_idx == 6'(RCC_PKT_LEN - 1)) begin
            next_rep_state = RCC_REP_IDLE;
          end else begin
            next_rep_idx = rep_idx + 6'h01;
            next_rep_data = rep_byte(rep_cfg, rep_idx + 6'h01);
          end
        end
      end
    endcase
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rep_state <= RCC_REP_IDLE;
      rep_cfg <= RCC_CFG_RESET;
      rep_idx <= 6'h00;
      rep_data <= 8'h00;
    end else begin
      rep_state <= next_rep_state;
      rep_cfg <= next_rep_cfg;
      rep_idx <= next_rep_idx;
      rep_data <= next_rep_data;
    end
  end

  assign REP_VALID = (rep_state == RCC_REP_SEND);
  assign REP_LAST = REP_VALID && (rep_idx == 6'(RCC_PKT_LEN - 1));
  assign REP_DATA = rep_data;

  // ****************************************
  // Status and active configuration outputs
  // ****************************************
  rcc_cfg_t cfg_out;
  rcc_cfg_t next_cfg_out;
  logic done;
  logic next_done;
  logic err;
  logic next_err;

  always_comb begin
    next_cfg_out = sets[act_state];
    next_done = do_write;
    next_err = bad_cmd;
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cfg_out <= RCC_CFG_RESET;
      done <= 1'b0;
      err <= 1'b0;
    end else begin
      cfg_out <= next_cfg_out;
      done <= next_done;
      err <= next_err;
    end
  end

  assign CMD_DONE = done;
  assign CMD_ERROR = err;
  assign ACTIVE_SET = act_state;
  assign CFG_DIM = cfg_out.dim;
  assign CFG_DGPS = cfg_out.dgps;
  assign CFG_DYN = cfg_out.dyn;
  assign CFG_ELEV = cfg_out.elev;
  assign CFG_SIG = cfg_out.sig;
  assign CFG_PDOP_MASK = cfg_out.pmask;
  assign CFG_PDOP_SWITCH = cfg_out.psw;
  assign CFG_SWITCH_EN = (cfg_out.dim == RCC_DIM_AUTO);
  assign CFG_AGE = cfg_out.age;

  // ****************************************
  // Satellite level hysteresis
  // ****************************************
  rcc_sat_if sat ();

  assign sat.level = SAT_LEVEL;
  assign sat.threshold = cfg_out.sig;
  assign sat.valid = SAT_VALID;
  assign sat.in_use = SAT_IN_USE;
  assign SAT_ADMIT = sat.admit;

  rcc_sat_filter #(
    .HYST(HYST)
  ) u_filter (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .sat(sat.filt)
  );

endmodule
`default_nettype wire

/* verification/rcc_top_sva.sv */
// Assertion checker for the receiver configuration handler
`timescale 1ns/1ns
`default_nettype none
module rcc_top_chk
  import rcc_pkg::*;
#(
  parameter logic [31:0] HYST = RCC_HYST_DEFAULT
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // Survey state and command stream
  input wire logic [1:0] SURVEY_STATE,
  input wire logic PKT_VALID,
  input wire logic PKT_FIRST,
  input wire logic PKT_LAST,
  input wire logic [7:0] PKT_DATA,
  input wire logic PKT_READY,
  // Report stream
  input wire logic REP_VALID,
  input wire logic REP_LAST,
  input wire logic [7:0] REP_DATA,
  input wire logic REP_READY,
  // Active configuration
  input wire logic [1:0] ACTIVE_SET,
  input wire logic [7:0] CFG_DIM,
  input wire logic [7:0] CFG_DGPS,
  input wire logic [7:0] CFG_DYN,
  input wire logic [31:0] CFG_ELEV,
  input wire logic [31:0] CFG_SIG,
  input wire logic CFG_SWITCH_EN,
  // Satellite level check
  input wire logic SAT_VALID,
  input wire logic SAT_IN_USE,
  input wire logic [31:0] SAT_LEVEL,
  input wire logic SAT_ADMIT
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  // ****************************************
  // Properties
  // ****************************************
  chk_set_follow: assert property (
    SURVEY_STATE != 2'h3 |=> ACTIVE_SET == $past(SURVEY_STATE))
    else $error("active set does not follow survey state");
  chk_query_answer: assert property (
    PKT_VALID && PKT_READY && PKT_FIRST && PKT_LAST && PKT_DATA == 8'h00
    |=> REP_VALID && REP_DATA == 8'h00) else $error("query not answered");
  chk_rep_hold: assert property (
    REP_VALID && !REP_READY |=> REP_VALID && $stable(REP_DATA) && $stable(REP_LAST))
    else $error("report byte changed while stalled");
  chk_rep_end: assert property (
    REP_VALID && REP_LAST && REP_READY |=> !REP_VALID && PKT_READY)
    else $error("report did not end after last byte");
  chk_switch_auto: assert property (
    CFG_SWITCH_EN == (CFG_DIM == RCC_DIM_AUTO)) else $error("switch enable wrong");
  chk_code_legal: assert property (
    CFG_DIM inside {8'h00, 8'h01, [8'h03:8'h07]} && CFG_DGPS inside {8'h00, 8'h01, 8'h03}
    && CFG_DYN inside {[8'h01:8'h04]}) else $error("illegal code stored");
  chk_elev_range: assert property (
    !CFG_ELEV[31] && CFG_ELEV <= RCC_ELEV_MAX) else $error("elevation out of range");
  chk_survey_set: assert property (
    ACTIVE_SET == 2'h1 && $past(ACTIVE_SET) == 2'h1 |-> CFG_DYN inside {[8'h01:8'h03]}
    && CFG_DIM inside {8'h00, 8'h03, 8'h04}) else $error("survey set restriction broken");
  chk_admit_new: assert property (
    SAT_VALID && !SAT_IN_USE && !SAT_LEVEL[31] && !CFG_SIG[31]
    && {1'b0, SAT_LEVEL} > {1'b0, CFG_SIG} + {1'b0, HYST} |=> SAT_ADMIT)
    else $error("new satellite above band refused");
  chk_admit_used: assert property (
    SAT_VALID && SAT_IN_USE && !SAT_LEVEL[31] && !CFG_SIG[31] && CFG_SIG >= HYST
    && SAT_LEVEL >= CFG_SIG - HYST |=> SAT_ADMIT) else $error("used satellite dropped");
  cov_report: cover property (REP_VALID && REP_LAST && REP_READY);
  cov_used: cover property (SAT_VALID && SAT_IN_USE);
  cov_timing: cover property (ACTIVE_SET == 2'h2);
endmodule

bind rcc_top rcc_top_chk #(.HYST(HYST)) i_chk (
  .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .SURVEY_STATE(SURVEY_STATE), .PKT_VALID(PKT_VALID),
  .PKT_FIRST(PKT_FIRST), .PKT_LAST(PKT_LAST), .PKT_DATA(PKT_DATA), .PKT_READY(PKT_READY),
  .REP_VALID(REP_VALID), .REP_LAST(REP_LAST), .REP_DATA(REP_DATA), .REP_READY(REP_READY),
  .ACTIVE_SET(ACTIVE_SET), .CFG_DIM(CFG_DIM), .CFG_DGPS(CFG_DGPS), .CFG_DYN(CFG_DYN),
  .CFG_ELEV(CFG_ELEV), .CFG_SIG(CFG_SIG), .CFG_SWITCH_EN(CFG_SWITCH_EN),
  .SAT_VALID(SAT_VALID), .SAT_IN_USE(SAT_IN_USE), .SAT_LEVEL(SAT_LEVEL), .SAT_ADMIT(SAT_ADMIT));
`default_nettype wire

/* verification/rcc_host_model.sv */
// Host model that sends command packets and takes reports
`timescale 1ns/1ns
`default_nettype none
module rcc_host_model (
  // Clock
  input wire logic clk,
  // Command stream
  output logic pkt_valid,
  output logic pkt_first,
  output logic pkt_last,
  output logic [7:0] pkt_data,
  input wire logic pkt_ready,
  // Report stream
  input wire logic rep_valid,
  input wire logic rep_last,
  input wire logic [7:0] rep_data,
  output logic rep_ready
);
  int seed = 32'h8605;
  logic slow = 1'b0;
  initial begin
    {pkt_valid, pkt_first, pkt_last, pkt_data, rep_ready} = 12'h001;
  end
  // Sink stall pattern
  always @(posedge clk) begin
    #1 rep_ready = slow ? 1'($random(seed)) : 1'b1;
  end
  // Bytes held until taken, data line scrambled when released
  task automatic send(input logic [7:0] b[$]);
    logic rdy;
    @(posedge clk);
    #1;
    for (int i = 0; i < b.size(); i++) begin
      pkt_valid = 1'b1;
      pkt_first = (i == 0);
      pkt_last = (i == b.size() - 1);
      pkt_data = b[i];
      do begin
        rdy = pkt_ready;
        @(posedge clk);
        #1;
      end while (!rdy);
    end
    pkt_valid = 1'b0;
    pkt_data = ~pkt_data;
  endtask
  // Collect one report, sampled while settled
  task automatic take(output logic [7:0] r[$]);
    logic fin;
    r = {};
    fin = 1'b0;
    for (int n = 0; n < 2000 && !fin; n++) begin
      @(negedge clk);
      fin = rep_valid && rep_ready && rep_last;
      if (rep_valid && rep_ready) r.push_back(rep_data);
      @(posedge clk);
    end
    #1;
  endtask
endmodule
`default_nettype wire

/* verification/rcc_top_tb.sv */
// Self-checking testbench of the receiver configuration handler
`timescale 1ns/1ns
`default_nettype none
module rcc_top_tb
  import rcc_pkg::*;
;
  localparam logic [31:0] H = RCC_HYST_DEFAULT;
  logic ref_clk = 1'b0;
  logic sys_rst, pkt_valid, pkt_first, pkt_last, pkt_ready, rep_valid, rep_last, rep_ready;
  logic cmd_done, cmd_error, cfg_sw, sat_valid, sat_in_use, sat_admit;
  logic [1:0] survey_state, active_set;
  logic [7:0] pkt_data, rep_data, cfg_dim, cfg_dgps, cfg_dyn, cfg_age;
  logic [31:0] cfg_elev, cfg_sig, cfg_pmask, cfg_psw, sat_level;
  logic [7:0] mdl [3][43];
  int fail_count = 0;
  int comparisons = 0;
  int seed = 32'h8605;
  int st = 0;
  always #5 ref_clk = ~ref_clk;
  rcc_top i_dut (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .SURVEY_STATE(survey_state),
    .PKT_VALID(pkt_valid), .PKT_FIRST(pkt_first), .PKT_LAST(pkt_last), .PKT_DATA(pkt_data),
    .PKT_READY(pkt_ready), .REP_VALID(rep_valid), .REP_LAST(rep_last), .REP_DATA(rep_data),
    .REP_READY(rep_ready), .CMD_DONE(cmd_done), .CMD_ERROR(cmd_error), .ACTIVE_SET(active_set),
    .CFG_DIM(cfg_dim), .CFG_DGPS(cfg_dgps), .CFG_DYN(cfg_dyn), .CFG_ELEV(cfg_elev),
    .CFG_SIG(cfg_sig), .CFG_PDOP_MASK(cfg_pmask), .CFG_PDOP_SWITCH(cfg_psw),
    .CFG_SWITCH_EN(cfg_sw), .CFG_AGE(cfg_age), .SAT_VALID(sat_valid), .SAT_IN_USE(sat_in_use),
    .SAT_LEVEL(sat_level), .SAT_ADMIT(sat_admit));
  rcc_host_model i_host (.clk(ref_clk), .pkt_valid(pkt_valid), .pkt_first(pkt_first),
    .pkt_last(pkt_last), .pkt_data(pkt_data), .pkt_ready(pkt_ready), .rep_valid(rep_valid),
    .rep_last(rep_last), .rep_data(rep_data), .rep_ready(rep_ready));
  // ****************************************
  // Model and checks
  // ****************************************
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] fw(int b);
    return {mdl[st][b], mdl[st][b+1], mdl[st][b+2], mdl[st][b+3]};
  endfunction
  task chk_cfg;
    check(active_set, st);
    check(cfg_dim, mdl[st][1]);
    check(cfg_dgps, mdl[st][2]);
    check(cfg_dyn, mdl[st][3]);
    check(cfg_elev, fw(5));
    check(cfg_sig, fw(9));
    check(cfg_pmask, fw(13));
    check(cfg_psw, fw(17));
    check(cfg_age, mdl[st][21]);
    check(cfg_sw, mdl[st][1] == 8'h00);
  endtask
  task automatic mdl_write(input logic [7:0] p[$]);
    logic [31:0] f;
    if (p[1] inside {0, 1, [3:7]} && (st != 1 || p[1] inside {0, 3, 4})
        && (st != 2 || p[1] inside {1, 7})) mdl[st][1] = p[1];
    if (p[2] inside {0, 1, 3}) mdl[st][2] = p[2];
    if (p[3] inside {[1:4]} && (st != 1 || p[3] != 4) && (st != 2 || p[3] == 4))
      mdl[st][3] = p[3];
    for (int b = 5; b < 21; b += 4) begin
      f = {p[b], p[b+1], p[b+2], p[b+3]};
      if (f != RCC_KEEP_FLOAT && (b != 5 || (!f[31] && f <= RCC_ELEV_MAX)))
        for (int k = 0; k < 4; k++) mdl[st][b+k] = f[31-8*k -: 8];
    end
    if (p[21] != 8'hff) mdl[st][21] = p[21];
  endtask
  // ****************************************
  // Stimulus tasks
  // ****************************************
  task set_state(input int s);
    survey_state = 2'(s);
    st = (s == 3) ? st : s;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic query;
    logic [7:0] r[$];
    fork
      i_host.send({8'h00});
      i_host.take(r);
      begin
        repeat (3) @(posedge ref_clk);
        #1;
        check(pkt_ready, 1'b0);
      end
    join
    check(pkt_ready, 1'b1);
    check(r.size(), 43);
    foreach (r[i]) check(r[i], mdl[st][i]);
  endtask
  task automatic write_rand;
    logic [7:0] p[$];
    logic [31:0] f;
    p = {8'h00};
    repeat (42) p.push_back((($random(seed) & 3) == 0) ? 8'hff : 8'($random(seed) & 7));
    for (int b = 5; b < 21; b += 4) begin
      case ($random(seed) & 3)
        0: f = RCC_KEEP_FLOAT;
        1: f = RCC_ELEV_MAX + 32'(b == 5);
        2: f = 32'hbe000000;
        default: f = {2'b00, 30'($random(seed))};
      endcase
      for (int k = 0; k < 4; k++) p[b+k] = f[31-8*k -: 8];
    end
    i_host.send(p);
    mdl_write(p);
    check(cmd_done, 1'b1);
    check(cmd_error, 1'b0);
    @(posedge ref_clk);
    #1;
    check(cmd_done, 1'b0);
    chk_cfg;
  endtask
  task automatic bad(input logic [7:0] p[$]);
    i_host.send(p);
    check(cmd_error, 1'b1);
    check(cmd_done, 1'b0);
    @(posedge ref_clk);
    #1;
    chk_cfg;
  endtask
  task automatic sat_test;
    logic [31:0] lvl;
    logic [31:0] t;
    logic used;
    t = fw(9);
    for (int i = 0; i < 24; i++) begin
      used = 1'($random(seed));
      lvl = (i == 0) ? 32'hc0800000 : t + 32'($random(seed) % 3145728);
      sat_valid = 1'b1;
      sat_in_use = used;
      sat_level = lvl;
      @(posedge ref_clk);
      #1;
      sat_valid = 1'b0;
      sat_level = ~lvl;
      check(sat_admit, !lvl[31] && (used ? lvl >= t - H : lvl > t + H));
    end
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [167:0] w;
    logic [7:0] p[$];
    {sys_rst, survey_state, sat_valid, sat_in_use, sat_level} = {4'h8, 33'h0};
    w = {RCC_DIM_3D, RCC_DGPS_AUTO, RCC_DYN_LAND, RCC_SOL_OVER, RCC_ELEV_RST, RCC_SIG_RST,
      RCC_PMASK_RST, RCC_PSW_RST, RCC_AGE_RST};
    for (int s = 0; s < 3; s++) begin
      for (int b = 0; b < 43; b++) mdl[s][b] = (b inside {23, 24} || b > 26) ? 8'hff : 8'h00;
      for (int k = 0; k < 21; k++) mdl[s][1+k] = w[167-8*k -: 8];
    end
    repeat (12) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    for (int s = 0; s < 4; s++) begin
      set_state(s);
      chk_cfg;
      query;
    end
    sat_test;
    $display("defaults, query and level check done");
    for (int s = 2; s >= 0; s--) begin
      set_state(s);
      repeat (12) write_rand;
      i_host.slow = (s == 1);
      query;
    end
    for (int s = 0; s < 3; s++) begin
      set_state(s);
      chk_cfg;
    end
    $display("writes per set done");
    // Mid-run reset restores defaults
    sys_rst = 1'b1;
    st = 0;
    for (int s = 0; s < 3; s++) begin
      for (int k = 0; k < 21; k++) mdl[s][1+k] = w[167-8*k -: 8];
    end
    @(posedge ref_clk);
    #1;
    chk_cfg;
    sys_rst = 1'b0;
    set_state(2);
    chk_cfg;
    bad({8'h00, 8'h04});
    bad({8'h05});
    p = {8'h01};
    repeat (42) p.push_back(8'h00);
    bad(p);
    p[0] = 8'h00;
    p.push_back(8'h00);
    bad(p);
    $display("refused packets done");
    give_verdict;
  end
  initial begin
    #400000;
    fail_count++;
    give_verdict;
  end
endmodule
`default_nettype wire
